// *** pkg/ias_pkg.sv ***
`default_nettype none
package ias_pkg;
    // Clock and instruction cycle timing
    localparam int CLK_HZ = 20000000;
    localparam int CLKS_PER_PHASE = 4;
    localparam int PHASES_PER_CYCLE = 4;
    localparam logic [3:0] CNT_FIRST = 4'h0;
    localparam logic [3:0] CNT_STEP = 4'h1;
    localparam logic [3:0] CNT_LAST = 4'hF;
    // Last clock of the second phase; the next edge is the one before the third phase
    localparam logic [3:0] CNT_RECOG = 4'h7;
    localparam int PHASE_LSB = 2;
    localparam int PHASE_W = 2;

    // Request sources, lowest index has the highest priority
    localparam int SRC_N = 3;
    localparam logic [SRC_N-1:0] SRC_NONE = 3'h0;

    // Status word width and its value after entry
    localparam int PSW_W = 5;
    localparam logic [PSW_W-1:0] PSW_CLEARED = 5'h00;

    // Sequencer state; Gray steps along execute, second table cycle, entry
    typedef enum logic [1:0] {
        IAS_EXEC = 2'h0,
        IAS_TM2 = 2'h1,
        IAS_ENTRY = 2'h3
    } ias_state_t;

    // What the instruction sequencer reports about the current instruction
    typedef struct packed {
        logic table_move;
        logic enable_irqs;
        logic disable_irqs;
        logic skip_taken;
    } ias_instr_t;

    // Strobes issued during the entry cycle
    typedef struct packed {
        logic save_pc;
        logic save_psw;
        logic clear_psw;
        logic [SRC_N-1:0] irq_clear;
    } ias_entry_t;

    // One-hot pick of the highest priority live request
    function automatic logic [SRC_N-1:0] ias_pick(input logic [SRC_N-1:0] live);
        logic [SRC_N-1:0] pick;
        pick = SRC_NONE;
        for (int i = SRC_N - 1; i >= 0; i--) begin
            if (live[i]) begin
                pick = SRC_NONE;
                pick[i] = 1'b1;
            end
        end
        return pick;
    endfunction
endpackage
`default_nettype wire

// *** src/ias_sequencer.sv ***
`timescale 1ns/10ps
`default_nettype none
module ias_sequencer (
    input wire logic clock_in, // CPU clock
    input wire logic rst_n_in, // Synchronous reset, active low
    input wire ias_pkg::ias_instr_t instr_in, // Current instruction from the sequencer
    input wire logic [ias_pkg::SRC_N-1:0] source_irq_pending_in, // Request flags
    input wire logic [ias_pkg::SRC_N-1:0] source_irq_enable_in, // Per-source enables
    output logic [1:0] machine_phase_out, // Phase within the instruction cycle
    output logic cycle_end_out, // Last clock of an instruction cycle
    output logic int_cycle_out, // Entry cycle in progress
    output logic table_move_second_out, // Second cycle of a table move
    output ias_pkg::ias_entry_t entry_out, // Entry strobes
    output logic [ias_pkg::PSW_W-1:0] psw_value_out, // Value to load into the status word
    output logic vector_fetch_out, // First clock of the vector fetch cycle
    output logic master_enable_out // Master interrupt enable
);
    logic [3:0] cnt_q;
    ias_pkg::ias_state_t state_q;
    logic inte_q;
    logic ei_arm_q;
    logic recog_q;
    ias_pkg::ias_entry_t entry_q;
    logic vector_q;
    logic [ias_pkg::SRC_N-1:0] live;
    logic request_live;
    logic cycle_end;
    logic recog_point;
    logic in_exec;
    logic gate;
    logic defer;
    logic take;

    // Cycle boundaries and recognition point
    assign cycle_end = (cnt_q == ias_pkg::CNT_LAST);
    assign recog_point = (cnt_q == ias_pkg::CNT_RECOG);
    assign in_exec = (state_q == ias_pkg::IAS_EXEC);
    assign live = source_irq_pending_in & source_irq_enable_in;
    assign request_live = (live != ias_pkg::SRC_NONE);
    // An enable instruction in flight already opens recognition, but never acceptance
    assign gate = inte_q | ei_arm_q | (in_exec & instr_in.enable_irqs);
    // Cycles after which a recognized request must still wait
    assign defer = in_exec
        & (instr_in.table_move | instr_in.skip_taken | instr_in.enable_irqs);
    // Acceptance needs the request still live at the boundary, so a vanished flag is dropped
    assign take = cycle_end & recog_q & request_live
        & (state_q != ias_pkg::IAS_ENTRY) & ~defer;

    // Free running clock counter inside the instruction cycle
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            cnt_q <= ias_pkg::CNT_FIRST;
        end else if (cycle_end) begin
            cnt_q <= ias_pkg::CNT_FIRST;
        end else begin
            cnt_q <= cnt_q + ias_pkg::CNT_STEP;
        end
    end

    // Instruction cycle sequencing
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_q <= ias_pkg::IAS_EXEC;
        end else if (cycle_end) begin
            case (state_q)
                ias_pkg::IAS_EXEC: begin
                    if (take) begin
                        state_q <= ias_pkg::IAS_ENTRY;
                    end else if (instr_in.table_move) begin
                        state_q <= ias_pkg::IAS_TM2;
                    end else begin
                        state_q <= ias_pkg::IAS_EXEC;
                    end
                end
                ias_pkg::IAS_TM2: begin
                    state_q <= take ? ias_pkg::IAS_ENTRY : ias_pkg::IAS_EXEC;
                end
                ias_pkg::IAS_ENTRY: begin
                    state_q <= ias_pkg::IAS_EXEC;
                end
                default: begin
                    state_q <= ias_pkg::IAS_EXEC;
                end
            endcase
        end
    end

    // Master enable; the enable instruction arms it and the next boundary sets it
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            inte_q <= 1'b0;
            ei_arm_q <= 1'b0;
        end else if (cycle_end) begin
            if (take || (in_exec && instr_in.disable_irqs)) begin
                inte_q <= 1'b0;
                ei_arm_q <= 1'b0;
            end else if (ei_arm_q) begin
                inte_q <= 1'b1;
                ei_arm_q <= 1'b0;
            end else if (in_exec && instr_in.enable_irqs) begin
                ei_arm_q <= 1'b1;
            end
        end
    end

    // Recognition latch; a deferring cycle carries it, any other boundary settles it
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            recog_q <= 1'b0;
        end else if (recog_point && gate && request_live && state_q != ias_pkg::IAS_ENTRY) begin
            recog_q <= 1'b1;
        end else if (cycle_end && !defer) begin
            recog_q <= 1'b0;
        end
    end

    // Entry strobes: save and clear on the first clock, status wipe on the second
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            entry_q <= '0;
        end else begin
            entry_q.save_pc <= take;
            entry_q.save_psw <= take;
            entry_q.irq_clear <= take ? ias_pkg::ias_pick(live) : ias_pkg::SRC_NONE;
            entry_q.clear_psw <= entry_q.save_psw;
        end
    end

    // Vector fetch marker right after the entry cycle
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            vector_q <= 1'b0;
        end else begin
            vector_q <= cycle_end && (state_q == ias_pkg::IAS_ENTRY);
        end
    end

    // Outputs
    assign machine_phase_out = cnt_q[ias_pkg::PHASE_LSB +: ias_pkg::PHASE_W];
    assign cycle_end_out = cycle_end;
    assign int_cycle_out = (state_q == ias_pkg::IAS_ENTRY);
    assign table_move_second_out = (state_q == ias_pkg::IAS_TM2);
    assign entry_out = entry_q;
    assign psw_value_out = ias_pkg::PSW_CLEARED;
    assign vector_fetch_out = vector_q;
    assign master_enable_out = inte_q;

    a_take_needs_enable: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        $rose(int_cycle_out) |-> $past(recog_q) && $past(request_live))
        else $error("entry without an enabled pending request");

    a_plain_accept: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (cycle_end && in_exec && recog_q && request_live && !defer)
        |=> int_cycle_out [*8])
        else $error("ordinary instruction did not lead to entry");

    a_table_move_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (cycle_end && in_exec && instr_in.table_move)
        |=> table_move_second_out ##15 table_move_second_out)
        else $error("table move second cycle missing");

    a_skip_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (cycle_end && in_exec && instr_in.skip_taken) |=> !int_cycle_out [*8])
        else $error("entry started during skipped cycle");

    a_entry_strobes: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        $rose(int_cycle_out) |-> entry_out.save_pc && entry_out.save_psw
        && $onehot(entry_out.irq_clear) ##1 entry_out.irq_clear == ias_pkg::SRC_NONE)
        else $error("entry strobes wrong");

    a_ei_delay: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (cycle_end && in_exec && instr_in.enable_irqs && !master_enable_out && !ei_arm_q)
        |=> !master_enable_out ##15 !master_enable_out)
        else $error("master enable set too early");

    a_ei_no_nest: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (cycle_end && in_exec && instr_in.enable_irqs) |=> !int_cycle_out [*8])
        else $error("interrupt taken right after enable");

    a_recog_edge: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        $rose(recog_q) |-> machine_phase_out == 2'h2 && $past(cnt_q) == ias_pkg::CNT_RECOG)
        else $error("recognition off the third phase edge");

    a_psw_wipe: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        entry_out.save_psw |=> entry_out.clear_psw
        && psw_value_out == ias_pkg::PSW_CLEARED)
        else $error("status word not cleared after save");

    a_entry_length: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        $rose(int_cycle_out) |-> ##15 int_cycle_out
        ##1 (!int_cycle_out && vector_fetch_out))
        else $error("entry cycle length or vector fetch wrong");

    a_cycle_period: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        cycle_end_out |=> !cycle_end_out [*8] ##8 cycle_end_out)
        else $error("instruction cycle not sixteen clocks");

    a_di_clears: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (cycle_end && in_exec && instr_in.disable_irqs) |=> !master_enable_out)
        else $error("master enable survived a disable instruction");

    a_entry_drops_enable: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        $rose(int_cycle_out) |-> !master_enable_out && !table_move_second_out)
        else $error("master enable still set in entry cycle");

    a_recog_gated: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        $rose(recog_q) |-> $past(gate) && $past(request_live) && !int_cycle_out)
        else $error("request recognized without enable");

    // The vector marker must follow the entry cycle directly and last one clock
    a_vector_single: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        vector_fetch_out |-> $past(int_cycle_out) && !int_cycle_out ##1 !vector_fetch_out)
        else $error("vector fetch marker misplaced");
endmodule
`default_nettype wire

// *** test/ias_src_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module ias_src_model (
    input wire logic clock_in, // CPU clock
    input wire logic rst_n_in, // Synchronous reset, active low
    input wire logic [ias_pkg::SRC_N-1:0] raise_in, // One-clock request events
    input wire logic [ias_pkg::SRC_N-1:0] irq_clear_in, // Clear strobes from entry
    output logic [ias_pkg::SRC_N-1:0] pending_out // Request flags
);
    logic [ias_pkg::SRC_N-1:0] flag_q;
    // A flag holds until entry clears it; a new event wins over a clear of the same source
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            flag_q <= ias_pkg::SRC_NONE;
        end else begin
            flag_q <= (flag_q & ~irq_clear_in) | raise_in;
        end
    end
    assign pending_out = flag_q;
endmodule
`default_nettype wire

// *** test/ias_sequencer_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module ias_sequencer_tb;
    logic clock_in, rst_n_in;
    ias_pkg::ias_instr_t instr;
    logic [2:0] raise, en, pend;
    logic [1:0] phase;
    logic cyc_end, int_cyc, tm2, vec, m_en;
    ias_pkg::ias_entry_t ent;
    logic [4:0] psw;
    int err_total, n_checks;
    localparam logic [3:0] I_NONE = 4'h0;
    localparam logic [3:0] I_TM = 4'h8;
    localparam logic [3:0] I_EI = 4'h4;
    localparam logic [3:0] I_SKIP = 4'h1;
    localparam logic [3:0] I_DI = 4'h2;

    ias_sequencer ias_sequencer_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .instr_in(instr),
        .source_irq_pending_in(pend), .source_irq_enable_in(en), .machine_phase_out(phase),
        .cycle_end_out(cyc_end), .int_cycle_out(int_cyc), .table_move_second_out(tm2),
        .entry_out(ent), .psw_value_out(psw), .vector_fetch_out(vec), .master_enable_out(m_en));
    ias_src_model ias_src_model_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .raise_in(raise),
        .irq_clear_in(ent.irq_clear), .pending_out(pend));

    // Free-running clock, 50 ns period
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    task automatic test_done();
        if (err_total == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One instruction cycle from clock 0; a request event is raised in clock `at`
    task automatic cyc(input logic [3:0] ins, input logic [2:0] rq, input int at);
        instr = ins;
        for (int i = 0; i < 16; i++) begin
            raise = (i == at) ? rq : 3'h0;
            @(negedge clock_in);
        end
        raise = 3'h0;
    endtask

    // Entered at clock 0 of the entry cycle, leaves at clock 0 of the vector cycle
    task automatic chk_entry(input logic [2:0] pick);
        chk("int_cycle", int_cyc, 8'h01);
        chk("save_pc", ent.save_pc, 8'h01);
        chk("save_psw", ent.save_psw, 8'h01);
        chk("irq_clear", ent.irq_clear, pick);
        @(negedge clock_in);
        chk("clear_psw", ent.clear_psw, 8'h01);
        chk("psw_value", psw, 8'h00);
        repeat (15) @(negedge clock_in);
        chk("vector_fetch", vec, 8'h01);
        chk("int_cycle_end", int_cyc, 8'h00);
    endtask

    // Recognized during the enable instruction, taken only after the next one
    task automatic s_ei_entry();
        cyc(I_NONE, 3'h1, 0);
        chk("no_master", int_cyc, 8'h00);
        cyc(I_EI, 3'h0, 0);
        chk("ei_wait", int_cyc, 8'h00);
        chk("ei_master", m_en, 8'h00);
        cyc(I_NONE, 3'h0, 0);
        chk_entry(3'h1);
    endtask

    // Disabled source held off, then enabled after the recognition point
    task automatic s_disabled();
        en = 3'h3;
        cyc(I_NONE, 3'h4, 0);
        cyc(I_EI, 3'h0, 0);
        cyc(I_NONE, 3'h0, 0);
        chk("master_set", m_en, 8'h01);
        cyc(I_NONE, 3'h0, 0);
        chk("src_off", int_cyc, 8'h00);
        repeat (9) @(negedge clock_in);
        en = 3'h7;
        repeat (7) @(negedge clock_in);
        chk("late_req", int_cyc, 8'h00);
        cyc(I_NONE, 3'h0, 0);
        chk_entry(3'h4);
    endtask

    // Table move and skipped instruction both delay entry by one cycle
    task automatic s_delay(input logic [3:0] ins, input logic [2:0] rq);
        cyc(I_EI, 3'h0, 0);
        cyc(I_NONE, 3'h0, 0);
        cyc(ins, rq, 0);
        chk("tm_second", tm2, (ins == I_TM) ? 8'h01 : 8'h00);
        chk("held_one", int_cyc, 8'h00);
        cyc(I_NONE, 3'h0, 0);
        chk_entry(rq);
    endtask

    // Waits for the last clock of a cycle, then steps to clock 0; a lost counter is a mismatch
    task automatic align(output bit ok);
        int k;
        k = 0;
        while (cyc_end !== 1'b1 && k < 40) begin
            @(negedge clock_in);
            k++;
        end
        ok = (k < 40);
        if (!ok) begin
            err_total++;
        end
        @(negedge clock_in);
    endtask

    // Phase and cycle boundary over one full instruction cycle
    task automatic s_phase();
        for (int i = 0; i < 16; i++) begin
            chk("phase", phase, 8'(i / 4));
            chk("cycle_end", cyc_end, (i == 15) ? 8'h01 : 8'h00);
            @(negedge clock_in);
        end
    endtask

    // Reset in mid-cycle drops the master enable and restarts the cycle counter
    task automatic s_reset();
        cyc(I_EI, 3'h0, 0);
        cyc(I_NONE, 3'h0, 0);
        chk("pre_reset_master", m_en, 8'h01);
        repeat (5) @(negedge clock_in);
        rst_n_in = 1'b0;
        repeat (2) @(negedge clock_in);
        chk("rst_master", m_en, 8'h00);
        chk("rst_phase", phase, 8'h00);
        chk("rst_int_cycle", int_cyc, 8'h00);
        chk("rst_table_second", tm2, 8'h00);
        chk("rst_strobes", ent, 8'h00);
        chk("rst_vector", vec, 8'h00);
        rst_n_in = 1'b1;
        chk("rel_cycle_end", cyc_end, 8'h00);
        repeat (15) @(negedge clock_in);
        chk("rel_phase", phase, 8'h03);
        chk("rel_last_clock", cyc_end, 8'h01);
        @(negedge clock_in);
    endtask

    // Disable instruction drops the master enable; a later request is then held off
    task automatic s_di();
        cyc(I_EI, 3'h0, 0);
        cyc(I_NONE, 3'h0, 0);
        chk("di_before", m_en, 8'h01);
        cyc(I_DI, 3'h0, 0);
        chk("di_after", m_en, 8'h00);
        cyc(I_NONE, 3'h1, 0);
        cyc(I_NONE, 3'h0, 0);
        chk("di_held", int_cyc, 8'h00);
        chk("di_pending", pend, 8'h01);
    endtask

    initial begin
        bit ok;
        rst_n_in = 1'b0;
        instr = I_NONE;
        raise = 3'h0;
        en = 3'h7;
        err_total = 0;
        n_checks = 0;
        repeat (20) @(negedge clock_in);
        rst_n_in = 1'b1;
        align(ok);
        if (ok) begin
            s_phase();
            s_ei_entry();
            s_disabled();
            s_delay(I_TM, 3'h2);
            s_delay(I_SKIP, 3'h1);
            s_reset();
            s_di();
        end
        test_done();
    end
endmodule
`default_nettype wire
